/* File: src/rxs_pkg.sv */
/*
 * Shared constants for the receive status and end-of-packet block.
 * Assumes a single 25 MHz system clock; the read clock is sampled.
 */
package rxs_pkg;
    localparam int          NUM_PORTS      = 4;
    localparam int          DATA_W         = 16;
    localparam int          LEVEL_W        = 8;
    localparam int          ADDR_W         = 5;
    localparam int          BASE_W         = 3;
    localparam int          SYNC_STAGES    = 2;
    localparam int          BUF_DEPTH      = 2;
    localparam logic [4:0]  NULL_ADDR      = 5'h1F;
    localparam logic [4:0]  WORD_LAST_EARLY = 5'h13;
    localparam logic [4:0]  WORD_LAST_LATE = 5'h18;
    localparam logic [4:0]  WORD_CNT_RESET = 5'h00;
    localparam logic        MOD_ONE_BYTE   = 1'b1;
    localparam logic        MOD_TWO_BYTES  = 1'b0;
endpackage : rxs_pkg

/* File: src/rxs_skid_buffer.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/1ps
module rxs_skid_buffer #(
    parameter int WIDTH = 18
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem [0:1];
    logic [WIDTH-1:0] next_mem0;
    logic [WIDTH-1:0] next_mem1;
    logic [1:0]       count;
    logic [1:0]       next_count;
    logic             pushOk;
    logic             popOk;

    always_comb begin
        pushOk     = inValid && (count != 2'h2);
        popOk      = outReady && (count != 2'h0);
        next_mem0  = mem[0];
        next_mem1  = mem[1];
        next_count = count;
        if (popOk) begin
            next_mem0 = mem[1];
        end
        if (pushOk) begin
            if (count == 2'h0 || (count == 2'h1 && popOk)) begin
                next_mem0 = inData;
            end else begin
                next_mem1 = inData;
            end
        end
        case ({pushOk, popOk})
            2'b10:   next_count = count + 2'h1;
            2'b01:   next_count = count - 2'h1;
            default: next_count = count;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
            count  <= 2'h0;
        end else begin
            mem[0] <= next_mem0;
            mem[1] <= next_mem1;
            count  <= next_count;
        end
    end

    assign inReady  = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData  = mem[0];

    AST_BUF_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
        count <= 2'h2)
        else $error("buffer count above depth");
endmodule : rxs_skid_buffer

/* File: src/rxs_rx_status.sv */
/*
 * Receive-side status and end-of-packet logic: direct cell and packet
 * available flags per port, and the word, end-of-packet and modulo
 * outputs toward the link layer.
 * Assumes the read clock arrives as a slow pin sampled by clk, and the
 * FIFO storage supplies words with start, end and odd-byte flags.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - one cell-available flag per port, four
// - setting picks drop at zero or five
// - polled in-use port drops after 24/19
// - cell-available changes on read clock rise
// - packet-available high on end or threshold
// - polarity bit inverts all packet-available
// - packet-available changes on read clock rise
// - all words full except the last
// - modulo high means one upper byte
// - modulo and end used in packet mode
// - modulo floats while enable is high
// - modulo floats for null or foreign address
// - end high exactly on last word
// - start and end may coincide
// - end floats on disable or foreign address
// - end and modulo change on clock rise
// - valid output qualifies end and modulo
module rxs_rx_status
    import rxs_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         readClk,
    input  wire logic                         readEnable_n,
    input  wire logic [rxs_pkg::ADDR_W-1:0]   readAddr,
    input  wire logic [rxs_pkg::BASE_W-1:0]   port_base_address,
    input  wire logic                         posMode,
    input  wire logic                         cell_avail_early_level,
    input  wire logic                         pkt_avail_polarity_invert,
    input  wire logic [rxs_pkg::LEVEL_W-1:0]  pktAvailThreshold,
    input  wire logic [rxs_pkg::NUM_PORTS-1:0] cellInFifo,
    input  wire logic [rxs_pkg::NUM_PORTS-1:0] eopInFifo,
    input  wire logic [rxs_pkg::NUM_PORTS*rxs_pkg::LEVEL_W-1:0] fifoLevel,
    input  wire logic                         wordValid,
    output logic                              wordReady,
    input  wire logic [rxs_pkg::DATA_W-1:0]   wordData,
    input  wire logic                         wordSop,
    input  wire logic                         wordEop,
    input  wire logic                         wordOdd,
    output logic [rxs_pkg::NUM_PORTS-1:0]     direct_cell_avail,
    output logic [rxs_pkg::NUM_PORTS-1:0]     direct_pkt_avail,
    output logic [rxs_pkg::DATA_W-1:0]        rxData,
    output logic                              rxStart,
    output logic                              rxEnd,
    output logic                              rxEndOe,
    output logic                              rxMod,
    output logic                              rxModOe,
    output logic                              rxValid
);
    import rxs_pkg::*;

    localparam int BUF_W = DATA_W + 3;

    logic [SYNC_STAGES-1:0] clkSync;
    logic [SYNC_STAGES-1:0] enSync;
    logic [ADDR_W-1:0]      addrMeta;
    logic [ADDR_W-1:0]      addrSync;
    logic                   clkPrev;
    logic                   rise;

    // Every pin from the link domain is brought in through two stages.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkSync  <= '0;
            enSync   <= '1;
            addrMeta <= NULL_ADDR;
            addrSync <= NULL_ADDR;
            clkPrev  <= 1'b0;
        end else begin
            clkSync  <= {clkSync[0], readClk};
            enSync   <= {enSync[0], readEnable_n};
            addrMeta <= readAddr;
            addrSync <= addrMeta;
            clkPrev  <= clkSync[1];
        end
    end

    assign rise = clkSync[1] && !clkPrev;

    logic              selected;
    logic              next_selected;
    logic [1:0]        curPort;
    logic [1:0]        next_curPort;
    logic [4:0]        wordCnt;
    logic [4:0]        next_wordCnt;
    logic [NUM_PORTS-1:0] next_cellAvail;
    logic [NUM_PORTS-1:0] next_pktAvail;
    logic [DATA_W-1:0] next_rxData;
    logic              next_rxStart;
    logic              next_rxEnd;
    logic              next_rxEndOe;
    logic              next_rxMod;
    logic              next_rxModOe;
    logic              next_rxValid;
    logic              addrMine;
    logic [1:0]        addrPort;
    logic              bufValid;
    logic              bufPop;
    logic [BUF_W-1:0]  bufData;
    logic [4:0]        lastWord;
    logic              enabled;

    rxs_skid_buffer #(.WIDTH(BUF_W)) uBuf (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (wordValid),
        .inReady  (wordReady),
        .inData   ({wordSop, wordEop, wordOdd, wordData}),
        .outValid (bufValid),
        .outReady (bufPop),
        .outData  (bufData)
    );

    always_comb begin
        enabled  = !enSync[1];
        addrPort = addrSync[1:0];
        // The high address bits must equal the base, low two pick a port.
        addrMine = (addrSync != NULL_ADDR) &&
                   (addrSync[4:2] == port_base_address);
        lastWord = cell_avail_early_level ? WORD_LAST_LATE
                                          : WORD_LAST_EARLY;
        bufPop   = rise && selected && enabled && posMode && !rxEnd;
        next_selected = selected;
        next_curPort  = curPort;
        next_wordCnt  = wordCnt;
        next_cellAvail = direct_cell_avail;
        next_pktAvail  = direct_pkt_avail;
        next_rxData   = rxData;
        next_rxStart  = rxStart;
        next_rxEnd    = rxEnd;
        next_rxEndOe  = rxEndOe;
        next_rxMod    = rxMod;
        next_rxModOe  = rxModOe;
        next_rxValid  = rxValid;
        // All outputs except wordReady move only on a rising edge of the read clock.
        if (rise) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                next_cellAvail[p] = cellInFifo[p];
                next_pktAvail[p] = pkt_avail_polarity_invert ^
                    (eopInFifo[p] ||
                     fifoLevel[p*LEVEL_W +: LEVEL_W] >=
                     pktAvailThreshold);
            end
            if (!posMode && selected && addrMine && addrPort == curPort &&
                wordCnt >= lastWord) begin
                next_cellAvail[curPort] = 1'b0;
            end
            if (!enabled) begin
                next_selected = 1'b0;
                next_wordCnt  = WORD_CNT_RESET;
            end else if (!selected) begin
                next_selected = addrMine;
                next_curPort  = addrPort;
                next_wordCnt  = WORD_CNT_RESET;
            end else if (!posMode) begin
                next_wordCnt = wordCnt + 5'h01;
            end
            next_rxEndOe = enabled && addrMine && posMode;
            next_rxModOe = enabled && addrMine && posMode;
            if (bufPop && bufValid) begin
                next_rxValid = 1'b1;
                next_rxData  = bufData[DATA_W-1:0];
                next_rxStart = bufData[DATA_W+2];
                next_rxEnd   = bufData[DATA_W+1];
                next_rxMod   = bufData[DATA_W+1] && bufData[DATA_W]
                               ? MOD_ONE_BYTE : MOD_TWO_BYTES;
            end else begin
                // Valid stays low for one rise after an end, since the pop waits on rxEnd.
                next_rxValid = 1'b0;
                next_rxStart = 1'b0;
                next_rxEnd   = 1'b0;
                next_rxMod   = MOD_TWO_BYTES;
            end
            if (!enabled) begin
                next_rxEnd = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selected          <= 1'b0;
            curPort           <= 2'h0;
            wordCnt           <= WORD_CNT_RESET;
            direct_cell_avail <= '0;
            direct_pkt_avail  <= '0;
            rxData            <= '0;
            rxStart           <= 1'b0;
            rxEnd             <= 1'b0;
            rxEndOe           <= 1'b0;
            rxMod             <= 1'b0;
            rxModOe           <= 1'b0;
            rxValid           <= 1'b0;
        end else begin
            selected          <= next_selected;
            curPort           <= next_curPort;
            wordCnt           <= next_wordCnt;
            direct_cell_avail <= next_cellAvail;
            direct_pkt_avail  <= next_pktAvail;
            rxData            <= next_rxData;
            rxStart           <= next_rxStart;
            rxEnd             <= next_rxEnd;
            rxEndOe           <= next_rxEndOe;
            rxMod             <= next_rxMod;
            rxModOe           <= next_rxModOe;
            rxValid           <= next_rxValid;
        end
    end

    AST_STABLE_NO_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        !rise |=> $stable(direct_cell_avail) && $stable(direct_pkt_avail) &&
                  $stable(rxEnd) && $stable(rxMod))
        else $error("outputs moved without a read clock rise");
    AST_MOD_ONLY_ON_END: assert property (@(posedge clk) disable iff (!rst_n)
        rxMod |-> rxEnd && rxValid)
        else $error("modulo high outside a final word");
    AST_END_WITH_VALID: assert property (@(posedge clk) disable iff (!rst_n)
        rxEnd |-> rxValid)
        else $error("end of packet without valid");
    AST_OE_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
        rise && enSync[1] |=> !rxModOe && !rxEndOe)
        else $error("modulo or end driven while enable is high level");
    AST_OE_NULL_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        rise && addrSync == NULL_ADDR |=> !rxModOe && !rxEndOe)
        else $error("outputs driven on null address");
    AST_OE_ATM: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !posMode |=> !rxModOe && !rxEndOe && !rxEnd)
        else $error("packet signals used in cell mode");
    AST_PKT_INV: assert property (@(posedge clk) disable iff (!rst_n)
        rise && pkt_avail_polarity_invert && eopInFifo[0] |=>
        !direct_pkt_avail[0])
        else $error("inverted packet available wrong");
    AST_PKT_EOP: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !pkt_avail_polarity_invert && eopInFifo[1] |=>
        direct_pkt_avail[1])
        else $error("packet available missing with end in fifo");
    AST_CELL_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !posMode && selected && addrMine && addrPort == curPort &&
        wordCnt >= lastWord |=> !direct_cell_avail[curPort])
        else $error("cell available did not drop at level");
    AST_CELL_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !cellInFifo[2] |=> !direct_cell_avail[2])
        else $error("cell available high with no cell");

    COV_ONE_WORD_PKT: cover property (@(posedge clk) rxStart && rxEnd);
    COV_ODD_END: cover property (@(posedge clk) rxEnd && rxMod);
    COV_CELL_DROP: cover property (@(posedge clk)
        $fell(direct_cell_avail[0]));
    COV_STALL: cover property (@(posedge clk) wordValid && !wordReady);
endmodule : rxs_rx_status

/* File: verification/rxs_link_model.sv */
/*
 * Link-layer reader model: makes the free-running read clock, selects
 * a port when asked and logs every word that it accepts.
 * Assumes the block settles its outputs well within half a read period.
 */
`timescale 1ns/1ps
module rxs_link_model (
    input  wire logic                       selReq,
    input  wire logic [rxs_pkg::ADDR_W-1:0] selAddr,
    output logic                            readClk,
    output logic                            readEnable_n,
    output logic      [rxs_pkg::ADDR_W-1:0] readAddr,
    input  wire logic [rxs_pkg::DATA_W-1:0] rxData,
    input  wire logic                       rxStart,
    input  wire logic                       rxEnd,
    input  wire logic                       rxMod,
    input  wire logic                       rxValid
);
    import rxs_pkg::*;
    logic [DATA_W-1:0] logData [$];
    logic [2:0]        logFlag [$];
    initial begin
        readClk = 1'b0;
        readEnable_n = 1'b1;
        readAddr = NULL_ADDR;
    end
    always #160 readClk = ~readClk;
    // Enable and address move just after a rise and hold for a full period.
    always @(posedge readClk) begin
        readEnable_n <= ~selReq;
        readAddr     <= selReq ? selAddr : NULL_ADDR;
    end
    // Sampling mid-period keeps clear of the block's update window.
    always @(negedge readClk) begin
        if (rxValid === 1'b1 && readEnable_n === 1'b0) begin
            logData.push_back((rxEnd && rxMod) ?
                {rxData[15:8], 8'h00} : rxData);
            logFlag.push_back({rxStart, rxEnd, rxMod});
        end
    end
endmodule : rxs_link_model

/* File: verification/tb_rxs_rx_status.sv */
/*
 * Self-checking bench for the receive status block: flag table, cell
 * drop counts, a buffered packet transfer and the output enables.
 * Assumes the link model in its own file and the shared package.
 */
`timescale 1ns/1ps
module tb_rxs_rx_status;
    import rxs_pkg::*;
    typedef struct {
        logic mode; logic inv; logic [3:0] cells; logic [3:0] eops;
        logic [31:0] lvl; logic [7:0] thr; logic [3:0] exp;
    } rxs_row_t;
    logic clk = 1'b0, rst_n = 1'b0, readClk, readEnable_n, selReq = 1'b0;
    logic [4:0] readAddr, selAddr = 5'h1F;
    logic [2:0] port_base_address = 3'h2;
    logic posMode = 1'b0, cell_avail_early_level = 1'b0;
    logic pkt_avail_polarity_invert = 1'b0, wordValid = 1'b0;
    logic wordSop = 1'b0, wordEop = 1'b0, wordOdd = 1'b0, wordReady;
    logic [7:0] pktAvailThreshold = 8'h00;
    logic [3:0] cellInFifo = 4'h0, eopInFifo = 4'h0;
    logic [3:0] direct_cell_avail, direct_pkt_avail;
    logic [31:0] fifoLevel = 32'h0;
    logic [15:0] wordData = 16'h0, rxData;
    logic rxStart, rxEnd, rxEndOe, rxMod, rxModOe, rxValid;
    int n_errors = 0, cmp_count = 0;
    rxs_row_t rows [6] = '{
        '{1'b0, 1'b0, 4'hA, 4'h0, 32'h0, 8'h00, 4'hA},
        '{1'b0, 1'b0, 4'h5, 4'h0, 32'h0, 8'h00, 4'h5},
        '{1'b1, 1'b0, 4'h0, 4'h1, 32'h00100F00, 8'h10, 4'h5},
        '{1'b1, 1'b1, 4'h0, 4'h1, 32'h00100F00, 8'h10, 4'hA},
        '{1'b1, 1'b0, 4'h0, 4'h0, 32'h0, 8'h00, 4'hF},
        '{1'b1, 1'b0, 4'h0, 4'h0, 32'h0, 8'h01, 4'h0}};
    logic [15:0] expD [4] = '{16'hA1B2, 16'hC3D4, 16'hE500, 16'h1234};
    logic [2:0]  expF [4] = '{3'b100, 3'b000, 3'b011, 3'b110};

    always #20 clk = ~clk;

    rxs_rx_status uut (.clk(clk), .rst_n(rst_n), .readClk(readClk),
        .readEnable_n(readEnable_n), .readAddr(readAddr),
        .port_base_address(port_base_address), .posMode(posMode),
        .cell_avail_early_level(cell_avail_early_level),
        .pkt_avail_polarity_invert(pkt_avail_polarity_invert),
        .pktAvailThreshold(pktAvailThreshold), .cellInFifo(cellInFifo),
        .eopInFifo(eopInFifo), .fifoLevel(fifoLevel),
        .wordValid(wordValid), .wordReady(wordReady),
        .wordData(wordData), .wordSop(wordSop), .wordEop(wordEop),
        .wordOdd(wordOdd), .direct_cell_avail(direct_cell_avail),
        .direct_pkt_avail(direct_pkt_avail), .rxData(rxData),
        .rxStart(rxStart), .rxEnd(rxEnd), .rxEndOe(rxEndOe),
        .rxMod(rxMod), .rxModOe(rxModOe), .rxValid(rxValid));

    rxs_link_model link (.selReq(selReq), .selAddr(selAddr),
        .readClk(readClk), .readEnable_n(readEnable_n),
        .readAddr(readAddr), .rxData(rxData), .rxStart(rxStart),
        .rxEnd(rxEnd), .rxMod(rxMod), .rxValid(rxValid));

    task automatic cmpVec(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpVec

    task automatic cmpBit(input logic got, input logic exp);
        cmpVec({15'h0, got}, {15'h0, exp});
    endtask : cmpBit

    task automatic waitRises(input int n);
        repeat (n) @(negedge readClk);
    endtask : waitRises

    task automatic select(input logic req, input logic [4:0] a);
        @(negedge clk);
        selReq = req;
        selAddr = a;
    endtask : select

    // The word stays offered until ready has been seen ahead of an edge.
    task automatic pushWord(input logic [15:0] d, input logic [2:0] f);
        int k;
        k = 0;
        @(negedge clk);
        wordValid = 1'b1;
        wordData = d;
        {wordSop, wordEop, wordOdd} = f;
        while (wordReady !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        wordValid = 1'b0;
    endtask : pushWord

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        #300000;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        foreach (rows[i]) begin
            @(negedge clk);
            posMode = rows[i].mode;
            pkt_avail_polarity_invert = rows[i].inv;
            cellInFifo = rows[i].cells;
            eopInFifo = rows[i].eops;
            fifoLevel = rows[i].lvl;
            pktAvailThreshold = rows[i].thr;
            waitRises(3);
            if (rows[i].mode)
                cmpVec({12'h0, direct_pkt_avail}, {12'h0, rows[i].exp});
            else
                cmpVec({12'h0, direct_cell_avail}, {12'h0, rows[i].exp});
        end
        posMode = 1'b0;
        cellInFifo = 4'hF;
        for (int e = 0; e < 2; e++) begin
            cell_avail_early_level = e[0];
            select(1'b1, 5'h09);
            waitRises(e ? 21 : 16);
            cmpBit(direct_cell_avail[1], 1'b1);
            waitRises(6);
            cmpBit(direct_cell_avail[1], 1'b0);
            cmpBit(rxModOe, 1'b0);
            select(1'b0, 5'h1F);
            waitRises(4);
        end
        posMode = 1'b1;
        pushWord(16'hA1B2, 3'b100);
        pushWord(16'hC3D4, 3'b000);
        cmpBit(wordReady, 1'b0);
        fork
            select(1'b1, 5'h09);
            begin
                pushWord(16'hE5FF, 3'b011);
                pushWord(16'h1234, 3'b110);
            end
        join
        waitRises(8);
        cmpBit(rxModOe, 1'b1);
        cmpBit(rxEndOe, 1'b1);
        select(1'b0, 5'h1F);
        waitRises(3);
        cmpBit(rxModOe, 1'b0);
        cmpBit(rxEndOe, 1'b0);
        cmpVec(16'(link.logData.size()), 16'h0004);
        for (int i = 0; i < 4; i++) begin
            cmpVec(link.logData[i], expD[i]);
            cmpVec({13'h0, link.logFlag[i]}, {13'h0, expF[i]});
        end
        select(1'b1, 5'h1F);
        waitRises(3);
        cmpBit(rxModOe, 1'b0);
        select(1'b1, 5'h11);
        waitRises(3);
        cmpBit(rxEndOe, 1'b0);
        cmpBit(rxModOe, 1'b0);
        select(1'b0, 5'h1F);
        end_sim();
    end
endmodule : tb_rxs_rx_status
